// ### inc/sdr_pkg.sv
// Package with register map, constants and state struct of the stepper driver register set
package sdr_pkg;

    // Serial datagram layout
    localparam int DGRAM_BITS = 40;
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 32;
    localparam int WR_FLAG_POS = 39;
    localparam int ADDR_MSB = 38;
    localparam int ADDR_LSB = 32;
    localparam logic [5:0] DGRAM_COUNT = 6'h28;
    localparam logic [7:0] SPI_STATUS_BYTE = 8'h00;

    // Register addresses
    localparam logic [6:0] ADDR_CHOPPER_CONFIG = 7'h6C;
    localparam logic [6:0] ADDR_SMART_CURRENT_STALL_CONFIG = 7'h6D;
    localparam logic [6:0] ADDR_AUTO_COMMUTATION_CONTROL = 7'h6E;
    localparam logic [6:0] ADDR_DRIVER_STATUS_WORD = 7'h6F;
    localparam logic [6:0] ADDR_VOLTAGE_PWM_CONFIG = 7'h70;
    localparam logic [6:0] ADDR_PWM_AMPLITUDE_RESULT = 7'h71;
    localparam logic [6:0] ADDR_PWM_LEARNED_DEFAULTS = 7'h72;
    localparam logic [6:0] ADDR_SKIPPED_STEP_COUNT = 7'h73;

    // Register widths and reset values
    localparam int SMART_CURRENT_BITS = 25;
    localparam int COMM_CTRL_BITS = 24;
    localparam int PWM_CONFIG_BITS = 22;
    localparam int SKIP_COUNT_BITS = 20;
    localparam logic [31:0] CHOPPER_CONFIG_RESET = 32'h10410150;
    localparam logic [31:0] VOLTAGE_PWM_CONFIG_RESET = 32'hC40C001E;

    // Field positions
    localparam int COMM_ON_LIMIT_MSB = 9;
    localparam int COMM_ON_LIMIT_LSB = 0;
    localparam int STEP_LOSS_LIMIT_MSB = 23;
    localparam int STEP_LOSS_LIMIT_LSB = 16;
    localparam int STEP_LOSS_UNIT_SHIFT = 4;
    localparam int CHOP_FULLSTEP_HV_BIT = 18;
    localparam int CHOP_SWITCH_HV_BIT = 19;
    localparam int RESULT_HIGH_LSB = 16;
    localparam int SCALE_SHIFT = 8;
    localparam int RESULT_BYTE_BITS = 8;
    localparam int RESULT_OFFSET_BITS = 9;

    // Default sine table
    localparam int TABLE_ENTRIES = 256;
    localparam real TABLE_AMPLITUDE = 248.0;
    localparam real TABLE_PERIOD = 1024.0;
    localparam real TABLE_PI = 3.14159265358979323846;
    localparam real ROUND_HALF = 0.5;
    localparam int TABLE_BIAS = 1;

    typedef logic signed [8:0] sdr_current_t;

    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic csn_s1;
        logic csn_s2;
        logic csn_d;
        logic sdi_s1;
        logic sdi_s2;
        logic step_s1;
        logic step_s2;
        logic step_d;
        logic dir_s1;
        logic dir_s2;
        logic ready_s1;
        logic ready_s2;
        logic mode_s1;
        logic mode_s2;
        logic en_s1;
        logic en_s2;
        logic [39:0] rx;
        logic [39:0] tx;
        logic [5:0] bit_cnt;
        logic [6:0] rd_addr;
        logic [31:0] chopper_config;
        logic [24:0] smart_current_stall_config;
        logic [23:0] auto_commutation_control;
        logic [21:0] voltage_pwm_config;
        logic [19:0] skipped_step_count;
        logic sdo;
        logic sdo_oe;
        logic auto_comm_active;
        logic step_loss_active;
        logic [11:0] step_loss_cycles;
        sdr_current_t scaled_a;
        sdr_current_t scaled_b;
        sdr_current_t table_value;
    } sdr_state_s;

endpackage

// ### hdl/sdr_register_set.sv
// Stepper driver register set behind the serial register port
`timescale 1ns/1ps

// Functional notes
// - Read/write 32-bit chopper word at 0x6C, reset 0x10410150.
// - Write-only 25-bit smart current and stall configuration word at 0x6D.
// - Word 0x6E bits 9:0 give commutation on-time limit in clock periods.
// - Word 0x6E bits 23:16 give step-loss limit in 16-clock units; zero disables.
// - Automatic commutation enabled by pin or nonzero minimum velocity.
// - With fullstep-at-high-velocity set, step-loss limit stays active above threshold.
// - Read-only 32-bit status word at 0x6F with load value and error flags.
// - Write-only 22-bit voltage PWM word at 0x70, reset 0xC40C001E.
// - Word 0x71 bits 7:0 report duty cycle; it scales phase table currents.
// - Word 0x71 bits 24:16 report signed amplitude offset, within +/-255.
// - Reported duty value 255 means maximum output voltage.
// - Word 0x72 bits 7:0 report learned PWM offset 0 to 255.
// - Word 0x72 bits 23:16 report learned PWM gradient 0 to 255.
// - Word 0x73 counts steps skipped while commutation-ready is low.
// - Skipped-step counter wraps modulo 2^20.
// - Skipped-step counter counts up or down by direction input.
// - Skipped-step counter works only when step/direction mode select is 1.
// - Default table entry i equals round(248*sin(2pi*i/1024+pi/1024)) minus 1.
// - Default table holds only the first quarter wave, from 0 up to a peak of +247.
// - Table rounding is round-half-up.
module sdr_register_set
    import sdr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial register port pins
    input wire logic spi_sck,
    input wire logic spi_csn,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // Step and direction pins
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic commutation_ready_out,
    input wire logic step_dir_mode_select,
    input wire logic auto_commutation_enable_pin,
    // Core state inputs
    input wire logic [22:0] auto_commutation_min_velocity,
    input wire logic above_high_velocity_threshold,
    input wire logic [31:0] driver_status_word,
    input wire logic [7:0] duty_cycle_sum,
    input wire logic signed [8:0] amplitude_offset_auto,
    input wire logic [7:0] learned_offset,
    input wire logic [7:0] learned_gradient,
    input wire logic signed [8:0] phase_a_table_current,
    input wire logic signed [8:0] phase_b_table_current,
    input wire logic [7:0] table_index,
    // Configuration outputs
    output logic [31:0] chopper_config,
    output logic [24:0] smart_current_stall_config,
    output logic [9:0] commutation_on_limit,
    output logic [11:0] step_loss_on_cycles,
    output logic step_loss_active,
    output logic auto_commutation_active,
    output logic [21:0] voltage_pwm_config,
    // Scaled currents and default table
    output logic signed [8:0] phase_a_scaled,
    output logic signed [8:0] phase_b_scaled,
    output logic signed [8:0] table_value
);

    function automatic sdr_current_t sine_entry(input int i);
        real x;
        x = TABLE_AMPLITUDE * $sin(2.0 * TABLE_PI * i / TABLE_PERIOD + TABLE_PI / TABLE_PERIOD);
        sine_entry = sdr_current_t'(int'($floor(x + ROUND_HALF)) - TABLE_BIAS);
    endfunction

    sdr_current_t sine_rom [TABLE_ENTRIES];

    // Default table, quarter wave from 0 to +247
    generate
        for (genvar g = 0; g < TABLE_ENTRIES; g++) begin : g_rom
            assign sine_rom[g] = sine_entry(g);
        end
    endgenerate

    localparam sdr_state_s STATE_RESET = '{
        csn_s1: 1'b1,
        csn_s2: 1'b1,
        csn_d: 1'b1,
        chopper_config: CHOPPER_CONFIG_RESET,
        voltage_pwm_config: VOLTAGE_PWM_CONFIG_RESET[PWM_CONFIG_BITS-1:0],
        default: '0
    };

    sdr_state_s st;
    sdr_state_s next_st;

    function automatic logic [31:0] read_word(input logic [6:0] a, input logic [19:0] lost);
        read_word = '0;
        if (a == ADDR_CHOPPER_CONFIG) begin
            read_word = st.chopper_config;
        end else if (a == ADDR_DRIVER_STATUS_WORD) begin
            read_word = driver_status_word;
        end else if (a == ADDR_PWM_AMPLITUDE_RESULT) begin
            read_word[RESULT_BYTE_BITS-1:0] = duty_cycle_sum;
            read_word[RESULT_HIGH_LSB +: RESULT_OFFSET_BITS] = amplitude_offset_auto;
        end else if (a == ADDR_PWM_LEARNED_DEFAULTS) begin
            read_word[RESULT_BYTE_BITS-1:0] = learned_offset;
            read_word[RESULT_HIGH_LSB +: RESULT_BYTE_BITS] = learned_gradient;
        end else if (a == ADDR_SKIPPED_STEP_COUNT) begin
            read_word[SKIP_COUNT_BITS-1:0] = lost;
        end
    endfunction

    always_comb begin
        logic sck_rise;
        logic sck_fall;
        logic cs_start;
        logic cs_end;
        logic step_rise;
        logic [7:0] loss_units;
        logic signed [18:0] prod_a;
        logic signed [18:0] prod_b;
        logic [39:0] frame;
        logic [6:0] waddr;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        cs_start = 1'b0;
        cs_end = 1'b0;
        step_rise = 1'b0;
        loss_units = '0;
        prod_a = '0;
        prod_b = '0;
        frame = '0;
        waddr = '0;
        next_st = st;

        // Pin synchronisers
        next_st.sck_s1 = spi_sck;
        next_st.sck_s2 = st.sck_s1;
        next_st.sck_d = st.sck_s2;
        next_st.csn_s1 = spi_csn;
        next_st.csn_s2 = st.csn_s1;
        next_st.csn_d = st.csn_s2;
        next_st.sdi_s1 = spi_sdi;
        next_st.sdi_s2 = st.sdi_s1;
        next_st.step_s1 = step_in;
        next_st.step_s2 = st.step_s1;
        next_st.step_d = st.step_s2;
        next_st.dir_s1 = dir_in;
        next_st.dir_s2 = st.dir_s1;
        next_st.ready_s1 = commutation_ready_out;
        next_st.ready_s2 = st.ready_s1;
        next_st.mode_s1 = step_dir_mode_select;
        next_st.mode_s2 = st.mode_s1;
        next_st.en_s1 = auto_commutation_enable_pin;
        next_st.en_s2 = st.en_s1;

        sck_rise = st.sck_s2 && !st.sck_d && !st.csn_s2;
        sck_fall = !st.sck_s2 && st.sck_d && !st.csn_s2;
        cs_start = !st.csn_s2 && st.csn_d;
        cs_end = st.csn_s2 && !st.csn_d;

        // Serial datagram engine
        if (cs_start) begin
            next_st.bit_cnt = '0;
            next_st.tx = {SPI_STATUS_BYTE, read_word(st.rd_addr, st.skipped_step_count)};
            next_st.sdo = SPI_STATUS_BYTE[7];
            next_st.sdo_oe = 1'b1;
        end else if (sck_rise) begin
            next_st.rx = {st.rx[DGRAM_BITS-2:0], st.sdi_s2};
            if (st.bit_cnt != DGRAM_COUNT) begin
                next_st.bit_cnt = st.bit_cnt + 6'h01;
            end
        end else if (sck_fall) begin
            next_st.tx = {st.tx[DGRAM_BITS-2:0], 1'b0};
            next_st.sdo = st.tx[DGRAM_BITS-2];
        end else if (cs_end) begin
            next_st.sdo_oe = 1'b0;
            next_st.sdo = 1'b0;
            if (st.bit_cnt == DGRAM_COUNT) begin
                frame = st.rx;
                waddr = frame[ADDR_MSB:ADDR_LSB];
                next_st.rd_addr = waddr;
                if (frame[WR_FLAG_POS]) begin
                    // Read-only addresses fall through untouched
                    if (waddr == ADDR_CHOPPER_CONFIG) begin
                        next_st.chopper_config = frame[DATA_BITS-1:0];
                    end else if (waddr == ADDR_SMART_CURRENT_STALL_CONFIG) begin
                        next_st.smart_current_stall_config = frame[SMART_CURRENT_BITS-1:0];
                    end else if (waddr == ADDR_AUTO_COMMUTATION_CONTROL) begin
                        next_st.auto_commutation_control = frame[COMM_CTRL_BITS-1:0];
                    end else if (waddr == ADDR_VOLTAGE_PWM_CONFIG) begin
                        next_st.voltage_pwm_config = frame[PWM_CONFIG_BITS-1:0];
                    end
                end
            end
        end

        // Automatic commutation enable
        next_st.auto_comm_active = st.en_s2 || (auto_commutation_min_velocity != '0);

        // Step-loss detection window
        loss_units = st.auto_commutation_control[STEP_LOSS_LIMIT_MSB:STEP_LOSS_LIMIT_LSB];
        next_st.step_loss_cycles = 12'(loss_units) << STEP_LOSS_UNIT_SHIFT;
        next_st.step_loss_active = st.auto_comm_active && (loss_units != '0)
            && (!above_high_velocity_threshold || st.chopper_config[CHOP_FULLSTEP_HV_BIT]);

        // Skipped-step counter
        step_rise = st.step_s2 && !st.step_d;
        if (step_rise && st.mode_s2 && st.auto_comm_active && !st.ready_s2) begin
            if (st.dir_s2) begin
                next_st.skipped_step_count = st.skipped_step_count - 20'h00001;
            end else begin
                next_st.skipped_step_count = st.skipped_step_count + 20'h00001;
            end
        end

        // Duty-cycle scaling of table currents
        prod_a = 19'(phase_a_table_current * $signed({1'b0, duty_cycle_sum}));
        prod_b = 19'(phase_b_table_current * $signed({1'b0, duty_cycle_sum}));
        next_st.scaled_a = prod_a[SCALE_SHIFT +: RESULT_OFFSET_BITS];
        next_st.scaled_b = prod_b[SCALE_SHIFT +: RESULT_OFFSET_BITS];

        next_st.table_value = sine_rom[table_index];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign spi_sdo = st.sdo;
    assign spi_sdo_oe = st.sdo_oe;
    assign chopper_config = st.chopper_config;
    assign smart_current_stall_config = st.smart_current_stall_config;
    assign commutation_on_limit = st.auto_commutation_control[COMM_ON_LIMIT_MSB:COMM_ON_LIMIT_LSB];
    assign step_loss_on_cycles = st.step_loss_cycles;
    assign step_loss_active = st.step_loss_active;
    assign auto_commutation_active = st.auto_comm_active;
    assign voltage_pwm_config = st.voltage_pwm_config;
    assign phase_a_scaled = st.scaled_a;
    assign phase_b_scaled = st.scaled_b;
    assign table_value = st.table_value;

endmodule

// ### dv/sdr_host_model.sv
// Host model driving the serial register port
`timescale 1ns/1ps
module sdr_host_model (
    // Clock
    input wire logic clock,
    // Serial port pins
    output logic spi_sck,
    output logic spi_csn,
    output logic spi_sdi,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe
);
    initial begin
        spi_sck = 1'b1;
        spi_csn = 1'b1;
        spi_sdi = 1'b0;
    end
    // One datagram, sck phases of 5 clocks, reply bit taken before each fall
    task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
        repeat (5) @(posedge clock);
        spi_csn <= 1'b0;
        for (int i = 39; i >= 0; i--) begin
            repeat (5) @(posedge clock);
            rx[i] = spi_sdo_oe ? spi_sdo : 1'bx;
            spi_sck <= 1'b0;
            spi_sdi <= tx[i];
            repeat (5) @(posedge clock);
            spi_sck <= 1'b1;
        end
        repeat (5) @(posedge clock);
        spi_csn <= 1'b1;
        spi_sdi <= ~spi_sdi;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ### dv/sdr_register_set_assertions.sv
// Port checker of the stepper driver register set
`timescale 1ns/1ps
module sdr_checker (
    // Watched ports
    input wire logic clock,
    input wire logic rst_n,
    input wire logic spi_csn,
    input wire logic [22:0] auto_commutation_min_velocity,
    input wire logic [7:0] duty_cycle_sum,
    input wire logic signed [8:0] phase_a_table_current,
    input wire logic [31:0] chopper_config,
    input wire logic [9:0] commutation_on_limit,
    input wire logic [11:0] step_loss_on_cycles,
    input wire logic step_loss_active,
    input wire logic auto_commutation_active,
    input wire logic [21:0] voltage_pwm_config,
    input wire logic signed [8:0] phase_a_scaled,
    input wire logic signed [8:0] table_value
);
    logic signed [17:0] prod_a;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence vel_set; (auto_commutation_min_velocity != 23'h0) [*2]; endsequence
    sequence limit_zero; (step_loss_on_cycles == 12'h0) [*3]; endsequence
    always_ff @(posedge clock) begin
        prod_a <= phase_a_table_current * $signed({1'b0, duty_cycle_sum});
    end
    chop_reset_a: assert property ($rose(rst_n) |-> chopper_config == 32'h10410150)
        else $error("chopper reset wrong");
    pwm_reset_a: assert property ($rose(rst_n) |-> voltage_pwm_config == 22'h0C001E)
        else $error("pwm reset wrong");
    step_unit_a: assert property (step_loss_on_cycles[3:0] == 4'h0)
        else $error("loss unit wrong");
    loss_off_a: assert property (limit_zero |-> !step_loss_active)
        else $error("loss active at zero");
    auto_on_a: assert property (vel_set |-> auto_commutation_active)
        else $error("auto off");
    duty_scale_a: assert property ($past(rst_n) |-> phase_a_scaled == prod_a[16:8])
        else $error("scale wrong");
    table_range_a: assert property (table_value <= 9'sh0F7 && table_value >= 9'sh108)
        else $error("table range");
    config_hold_a: assert property ($changed(commutation_on_limit) || $changed(chopper_config)
        |-> $past(spi_csn)) else $error("change in datagram");
endmodule

bind sdr_register_set sdr_checker sdr_checker_inst (.clock, .rst_n, .spi_csn, .auto_commutation_min_velocity,
    .duty_cycle_sum, .phase_a_table_current, .chopper_config, .commutation_on_limit, .step_loss_on_cycles,
    .step_loss_active, .auto_commutation_active, .voltage_pwm_config, .phase_a_scaled, .table_value);

// ### dv/sdr_register_set_tb_top.sv
// Self-checking bench of the stepper driver register set
`timescale 1ns/1ps
module sdr_register_set_tb_top;
    logic clock = 1'b0, rst_n = 1'b0, step_in = 1'b0, dir_in = 1'b0;
    logic commutation_ready_out = 1'b0, step_dir_mode_select = 1'b0;
    logic auto_commutation_enable_pin = 1'b0, above_high_velocity_threshold = 1'b0;
    logic [22:0] auto_commutation_min_velocity = 23'h0;
    logic [31:0] driver_status_word = 32'h0;
    logic [7:0] duty_cycle_sum = 8'h0, learned_offset = 8'h0, learned_gradient = 8'h0, table_index = 8'h0;
    logic signed [8:0] amplitude_offset_auto = 9'h0, phase_a_table_current = 9'h0, phase_b_table_current = 9'h0;
    logic spi_sck, spi_csn, spi_sdi, spi_sdo, spi_sdo_oe, step_loss_active, auto_commutation_active;
    logic [31:0] chopper_config;
    logic [24:0] smart_current_stall_config;
    logic [9:0] commutation_on_limit;
    logic [11:0] step_loss_on_cycles;
    logic [21:0] voltage_pwm_config;
    logic signed [8:0] phase_a_scaled, phase_b_scaled, table_value;
    logic [39:0] rx;
    int mismatches = 0;
    int comparisons = 0;

    always #2.5 clock = ~clock;

    sdr_host_model sdr_host_model_inst (.clock, .spi_sck, .spi_csn, .spi_sdi, .spi_sdo, .spi_sdo_oe);
    sdr_register_set sdr_register_set_inst (.clock, .rst_n, .spi_sck, .spi_csn, .spi_sdi, .spi_sdo, .spi_sdo_oe,
        .step_in, .dir_in, .commutation_ready_out, .step_dir_mode_select, .auto_commutation_enable_pin,
        .auto_commutation_min_velocity, .above_high_velocity_threshold, .driver_status_word, .duty_cycle_sum,
        .amplitude_offset_auto, .learned_offset, .learned_gradient, .phase_a_table_current,
        .phase_b_table_current, .table_index, .chopper_config, .smart_current_stall_config,
        .commutation_on_limit, .step_loss_on_cycles, .step_loss_active, .auto_commutation_active,
        .voltage_pwm_config, .phase_a_scaled, .phase_b_scaled, .table_value);

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        sdr_host_model_inst.xfer({1'b1, a, d}, rx);
    endtask
    // Reply of a read comes in the following datagram
    task automatic rd(input logic [6:0] a, input logic [31:0] exp);
        sdr_host_model_inst.xfer({1'b0, a, 32'h0}, rx);
        sdr_host_model_inst.xfer({1'b0, a, 32'h0}, rx);
        cmp($sformatf("word %h", a), exp, rx[31:0]);
    endtask
    task automatic steps(input int n);
        repeat (n) begin
            repeat (5) @(posedge clock);
            step_in <= 1'b1;
            repeat (5) @(posedge clock);
            step_in <= 1'b0;
        end
    endtask
    function automatic logic [31:0] sine(input int i);
        real x;
        x = 248.0 * $sin(2.0 * 3.14159265358979 * i / 1024.0 + 3.14159265358979 / 1024.0);
        return 32'($rtoi($floor(x + 0.5)) - 1);
    endfunction
    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(7'h6C, 32'h10410150);
        wr(7'h6C, 32'hA5F00F5A);
        cmp("chopper", 32'hA5F00F5A, chopper_config);
        rd(7'h6C, 32'hA5F00F5A);
        wr(7'h6D, 32'hFFFFFFFF);
        cmp("smart", 32'h01FFFFFF, 32'(smart_current_stall_config));
        rd(7'h6D, 32'h0);
        wr(7'h70, 32'hFFFFFFFF);
        cmp("pwm", 32'h003FFFFF, 32'(voltage_pwm_config));
        auto_commutation_min_velocity <= 23'h100;
        wr(7'h6E, 32'h004103FF);
        cmp("on_limit", 32'h3FF, 32'(commutation_on_limit));
        cmp("loss_cycles", 32'h410, 32'(step_loss_on_cycles));
        cmp("loss", 32'h1, 32'(step_loss_active));
        above_high_velocity_threshold <= 1'b1;
        repeat (4) @(posedge clock);
        cmp("loss", 32'h0, 32'(step_loss_active));
        wr(7'h6C, 32'hA5F40F5A);
        cmp("loss", 32'h1, 32'(step_loss_active));
        auto_commutation_min_velocity <= 23'h0;
        auto_commutation_enable_pin <= 1'b1;
        wr(7'h6E, 32'h000003FF);
        cmp("auto", 32'h1, 32'(auto_commutation_active));
        cmp("loss", 32'h0, 32'(step_loss_active));
        driver_status_word <= 32'hA5C30F1E;
        duty_cycle_sum <= 8'hFF;
        amplitude_offset_auto <= 9'h101;
        learned_offset <= 8'h12;
        learned_gradient <= 8'hEF;
        phase_a_table_current <= 9'h0F7;
        phase_b_table_current <= 9'h108;
        wr(7'h6F, 32'h0);
        rd(7'h6F, 32'hA5C30F1E);
        rd(7'h71, 32'h010100FF);
        cmp("scaled_a", 32'h0F6, {23'h0, phase_a_scaled});
        cmp("scaled_b", 32'h108, {23'h0, phase_b_scaled});
        rd(7'h72, 32'h00EF0012);
        rd(7'h10, 32'h0);
        step_dir_mode_select <= 1'b1;
        steps(3);
        rd(7'h73, 32'h3);
        dir_in <= 1'b1;
        steps(5);
        rd(7'h73, 32'hFFFFE);
        commutation_ready_out <= 1'b1;
        steps(2);
        rd(7'h73, 32'hFFFFE);
        commutation_ready_out <= 1'b0;
        step_dir_mode_select <= 1'b0;
        steps(2);
        wr(7'h73, 32'h0);
        rd(7'h73, 32'hFFFFE);
        for (int i = 0; i < 256; i++) begin
            table_index <= 8'(i);
            repeat (3) @(posedge clock);
            cmp("table", sine(i), 32'(table_value));
        end
        print_verdict();
    end
endmodule
